// ### design/miws_ctrl.sv
// Behaviour
// - reset by power-on, pin, enabled watchdog
// - power-on sets both; pin/LOW_VOLTAGE_RESET keep or wake
// - watchdog reset 0/1, watchdog wake 0/0
// - clear sets 1/1, sleep 1/0, timeout clears cause (code: not while asleep with the watchdog disabled)
// - pin-change wake gives cause 1, dozed 0
// - pin change wakes; resumes or vectors 006H
// - external input filter 8 clocks, bypass LOW_FREQ_CRYSTAL_MODE
// - edge select bit; external vectors 003H
// - enable/disable instructions; pending redirects fetch
// - flags set regardless of mask, except pin-change
// - flag read returns flags AND mask
// - return re-enables global interrupts
// - save working set, restore, newest overwrites
// - vectors 003H, 006H, 009H with priorities
// - conversion 00CH, comparator 00FH
// - timers 012H, 015H, 018H on match
// - low-voltage 01BH highest priority
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module miws_ctrl
   import miws_pkg::*;
(
   // APB
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Core instructions and state, one-cycle strobes
   input  wire logic        irq_global_on_instr,
   input  wire logic        irq_global_off_instr,
   input  wire logic        irq_return_instr,
   input  wire logic        sleep_instr,
   input  wire logic        watchdog_clear_instr,
   input  wire logic        asleep,
   // Reset causes
   input  wire logic        pin_reset_n,
   input  wire logic        low_voltage_reset,
   input  wire logic        watchdog_timeout,
   // Event sources
   input  wire logic        ext_pin,
   input  wire logic [7:0]  port6_in,
   input  wire logic        port6_read,
   input  wire logic        base_timer_ovf,
   input  wire logic        conv_done,
   input  wire logic        cmp_change,
   input  wire logic [2:0]  timer_match,
   input  wire logic        lvd_event,
   // Core working set
   input  wire logic [23:0] work_set_in,
   // Outputs to core
   output logic             core_reset,
   output logic             wake,
   output logic             vector_req,
   output logic [9:0]       vector_addr,
   output logic [23:0]      work_set_out,
   output logic             watchdog_cause,
   output logic             dozed
);
   // -----------------------------------------------------------------------
   // State
   // -----------------------------------------------------------------------
   logic [8:0]  irq_flag_reg, next_flag;
   logic [8:0]  irq_mask_reg, next_mask;
   logic [2:0]  core_ctrl_reg, next_ctrl;
   logic        gie, next_gie;
   logic        next_wdc, next_dozed;
   logic [7:0]  port6_ref, next_ref;
   logic [2:0]  filt_cnt, next_filt_cnt;
   logic        ext_filt, next_ext_filt;
   logic        ext_prev, next_ext_prev;
   logic [23:0] saved, next_saved;
   logic [23:0] save_reg, next_save_reg;
   logic        next_vreq, next_wake, next_core_reset;
   logic [9:0]  next_vaddr;
   logic [31:0] next_prdata;

   logic        wr, rd, hit, pin_chg, ext_raw, ext_level, ext_edge, wd_rst;
   logic [8:0]  events, pending;
   logic [9:0]  vec;

   assign pready  = 1'b1;  // Zero wait states
   assign wr      = psel & penable & pwrite;
   assign rd      = psel & ~penable & ~pwrite;
   assign hit     = (paddr <= MIWS_OFF_SAVED) && (paddr[1:0] == 2'b00);
   assign pslverr = psel & penable & ~hit;
   assign wd_rst  = watchdog_timeout & core_ctrl_reg[MIWS_C_WDEN];

   // -----------------------------------------------------------------------
   // Event detection
   // -----------------------------------------------------------------------
   always_comb begin
      ext_raw = ext_pin ^ core_ctrl_reg[MIWS_C_EDGE];
      ext_level = core_ctrl_reg[MIWS_C_LXT] ? ext_raw : ext_filt;
      ext_edge  = ext_level & ~ext_prev;
      pin_chg   = |(port6_in ^ port6_ref);
      events = 9'h000;
      events[MIWS_B_TIMER]  = base_timer_ovf;
      events[MIWS_B_PINCHG] = pin_chg & irq_mask_reg[MIWS_B_PINCHG];
      events[MIWS_B_EXT]    = ext_edge;
      events[MIWS_B_CONV]   = conv_done;
      events[MIWS_B_T1]     = timer_match[0];
      events[MIWS_B_T2]     = timer_match[1];
      events[MIWS_B_T3]     = timer_match[2];
      events[MIWS_B_CMP]    = cmp_change;
      events[MIWS_B_LVD]    = lvd_event;
      pending = irq_flag_reg & irq_mask_reg;
      if (pending[MIWS_B_LVD])         vec = MIWS_VEC_LVD;
      else if (pending[MIWS_B_EXT])    vec = MIWS_VEC_EXT;
      else if (pending[MIWS_B_PINCHG]) vec = MIWS_VEC_PINCHG;
      else if (pending[MIWS_B_TIMER])  vec = MIWS_VEC_TIMER;
      else if (pending[MIWS_B_CONV])   vec = MIWS_VEC_CONV;
      else if (pending[MIWS_B_CMP])    vec = MIWS_VEC_CMP;
      else if (pending[MIWS_B_T1])     vec = MIWS_VEC_T1;
      else if (pending[MIWS_B_T2])     vec = MIWS_VEC_T2;
      else                             vec = MIWS_VEC_T3;
   end

   // -----------------------------------------------------------------------
   // Next values
   // -----------------------------------------------------------------------
   always_comb begin
      next_mask      = irq_mask_reg;
      next_ctrl      = core_ctrl_reg;
      next_save_reg  = save_reg;
      next_ref       = port6_read ? port6_in : port6_ref;
      next_ext_prev  = ext_level;
      next_ext_filt  = ext_filt;
      next_filt_cnt  = 3'h0;
      next_gie       = gie;
      next_wdc       = watchdog_cause;
      next_dozed     = dozed;
      next_saved     = saved;
      next_vreq      = 1'b0;
      next_vaddr     = vector_addr;
      next_wake      = 1'b0;
      next_prdata    = prdata;
      next_core_reset = ~pin_reset_n | wd_rst | low_voltage_reset;
      if (ext_raw != ext_filt) begin
         next_filt_cnt = filt_cnt + 3'h1;
         if (filt_cnt == 3'(MIWS_FILT_CYC - 1)) begin
            next_ext_filt = ext_raw;
            next_filt_cnt = 3'h0;
         end
      end
      if (rd) begin
         unique case (paddr)
            MIWS_OFF_FLAG:   next_prdata = {23'h0, irq_flag_reg & irq_mask_reg};
            MIWS_OFF_MASK:   next_prdata = {23'h0, irq_mask_reg};
            MIWS_OFF_CTRL:   next_prdata = {29'h0, core_ctrl_reg};
            MIWS_OFF_STATUS: next_prdata = {29'h0, gie, dozed, watchdog_cause};
            MIWS_OFF_SAVE:   next_prdata = {8'h0, save_reg};
            MIWS_OFF_SAVED:  next_prdata = {8'h0, saved};
            default:         next_prdata = 32'h0;
         endcase
      end
      // Software clear: writing 1 clears
      next_flag = irq_flag_reg;
      if (wr && paddr == MIWS_OFF_FLAG) next_flag = next_flag & ~pwdata[8:0];
      if (wr && paddr == MIWS_OFF_MASK) next_mask = pwdata[8:0];
      if (wr && paddr == MIWS_OFF_CTRL) next_ctrl = pwdata[2:0];
      if (wr && paddr == MIWS_OFF_SAVE) next_save_reg = pwdata[23:0];
      next_flag = next_flag | events;
      if (irq_global_on_instr | irq_return_instr) next_gie = 1'b1;
      if (irq_global_off_instr) next_gie = 1'b0;
      if (irq_return_instr) begin
         next_saved = work_set_in;
      end
      if (watchdog_clear_instr) begin
         next_wdc   = 1'b1;
         next_dozed = 1'b1;
      end else if (sleep_instr) begin
         next_wdc   = 1'b1;
         next_dozed = 1'b0;
      end
      if (asleep) begin
         if (wd_rst) begin
            next_wdc   = 1'b0;
            next_dozed = 1'b0;
         end else if (~pin_reset_n | low_voltage_reset) begin
            next_wdc   = 1'b1;
            next_dozed = 1'b0;
         end else if (pin_chg & irq_mask_reg[MIWS_B_PINCHG]) begin
            next_wdc   = 1'b1;
            next_dozed = 1'b0;
            next_wake  = 1'b1;
         end else if (|pending) begin
            next_wake  = 1'b1;
         end
      end else if (wd_rst) begin
         next_wdc   = 1'b0;
         next_dozed = 1'b1;
      end else if (watchdog_timeout) begin
         next_wdc   = 1'b0;
      end
      if (gie && |pending && !irq_global_off_instr && !vector_req) begin
         next_vreq  = 1'b1;
         next_vaddr = vec;
         next_gie   = 1'b0;
         next_saved = work_set_in;
      end
   end

   // -----------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flag_reg   <= MIWS_FLAG_RST;
         irq_mask_reg   <= MIWS_MASK_RST;
         core_ctrl_reg  <= MIWS_CTRL_RST;
         gie            <= 1'b0;
         watchdog_cause <= 1'b1;
         dozed          <= 1'b1;
         port6_ref      <= 8'h00;
         filt_cnt       <= 3'h0;
         ext_filt       <= 1'b0;
         ext_prev       <= 1'b0;
         saved          <= 24'h000000;
         save_reg       <= 24'h000000;
         vector_req     <= 1'b0;
         vector_addr    <= 10'h000;
         wake           <= 1'b0;
         core_reset     <= 1'b1;
         prdata         <= 32'h0;
      end else begin
         irq_flag_reg   <= next_flag;
         irq_mask_reg   <= next_mask;
         core_ctrl_reg  <= next_ctrl;
         gie            <= next_gie;
         watchdog_cause <= next_wdc;
         dozed          <= next_dozed;
         port6_ref      <= next_ref;
         filt_cnt       <= next_filt_cnt;
         ext_filt       <= next_ext_filt;
         ext_prev       <= next_ext_prev;
         saved          <= next_saved;
         save_reg       <= next_save_reg;
         vector_req     <= next_vreq;
         vector_addr    <= next_vaddr;
         wake           <= next_wake;
         core_reset     <= next_core_reset;
         prdata         <= next_prdata;
      end
   end

   assign work_set_out = saved;

   // -----------------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------------
   property p_pinrst;
      @(posedge pclk) disable iff (!presetn) !pin_reset_n |=> core_reset;
   endproperty
   a_pinrst: assert property (p_pinrst) else $error("pin reset not followed");

   property p_clear_cause;
      @(posedge pclk) disable iff (!presetn)
         watchdog_clear_instr && !asleep && !watchdog_timeout |=> watchdog_cause && dozed;
   endproperty
   a_clear_cause: assert property (p_clear_cause) else $error("clear did not set cause bits");

   property p_wd_run;
      @(posedge pclk) disable iff (!presetn)
         !asleep && wd_rst |=> !watchdog_cause && dozed;
   endproperty
   a_wd_run: assert property (p_wd_run) else $error("watchdog reset cause wrong");

   property p_masked_read;
      @(posedge pclk) disable iff (!presetn)
         rd && paddr == MIWS_OFF_FLAG |=> prdata[8:0] == ($past(irq_flag_reg) & $past(irq_mask_reg));
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("flag read not masked");

   property p_flag_set;
      @(posedge pclk) disable iff (!presetn) base_timer_ovf |=> irq_flag_reg[MIWS_B_TIMER];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("timer flag not set");

   property p_return_on;
      @(posedge pclk) disable iff (!presetn)
         irq_return_instr && !irq_global_off_instr && !(|pending) |=> gie;
   endproperty
   a_return_on: assert property (p_return_on) else $error("return did not enable");

   property p_lvd_first;
      @(posedge pclk) disable iff (!presetn)
         gie && !vector_req && !irq_global_off_instr && pending[MIWS_B_LVD]
         |=> vector_req && vector_addr == MIWS_VEC_LVD;
   endproperty
   a_lvd_first: assert property (p_lvd_first) else $error("low-voltage not first");

   property p_ext_vec;
      @(posedge pclk) disable iff (!presetn)
         gie && !vector_req && !irq_global_off_instr && pending == 9'(1 << MIWS_B_EXT)
         |=> vector_addr == MIWS_VEC_EXT;
   endproperty
   a_ext_vec: assert property (p_ext_vec) else $error("external vector wrong");

   property p_save;
      @(posedge pclk) disable iff (!presetn) $rose(vector_req) |-> work_set_out == $past(work_set_in);
   endproperty
   a_save: assert property (p_save) else $error("working set not saved");
endmodule
`default_nettype wire

// ### shared/miws_pkg.sv
package miws_pkg;
   // --------------------------------------------------------------------------
   // Register byte addresses on APB
   // --------------------------------------------------------------------------
   localparam logic [11:0] MIWS_OFF_FLAG   = 12'h000;  // irq_flag_reg, masked on read
   localparam logic [11:0] MIWS_OFF_MASK   = 12'h004;  // irq_mask_reg
   localparam logic [11:0] MIWS_OFF_CTRL   = 12'h008;  // core_ctrl_reg
   localparam logic [11:0] MIWS_OFF_STATUS = 12'h00C;  // cause bits, global enable
   localparam logic [11:0] MIWS_OFF_SAVE   = 12'h010;  // save_reg, software read and write
   localparam logic [11:0] MIWS_OFF_SAVED  = 12'h014;  // restored working set, read

   // --------------------------------------------------------------------------
   // Flag bit positions
   // --------------------------------------------------------------------------
   localparam int MIWS_NSRC      = 9;
   localparam int MIWS_B_TIMER   = 0;
   localparam int MIWS_B_PINCHG  = 1;
   localparam int MIWS_B_EXT     = 2;
   localparam int MIWS_B_CONV    = 3;
   localparam int MIWS_B_T1      = 4;
   localparam int MIWS_B_T2      = 5;
   localparam int MIWS_B_T3      = 6;
   localparam int MIWS_B_CMP     = 7;
   localparam int MIWS_B_LVD     = 8;

   // Control bit positions
   localparam int MIWS_C_EDGE    = 0;  // ext_edge_select: 1 = falling
   localparam int MIWS_C_LXT     = 1;  // low_freq_crystal_mode
   localparam int MIWS_C_WDEN    = 2;  // watchdog enable

   // --------------------------------------------------------------------------
   // Vectors and values after reset
   // --------------------------------------------------------------------------
   localparam logic [9:0] MIWS_VEC_EXT    = 10'h003;
   localparam logic [9:0] MIWS_VEC_PINCHG = 10'h006;
   localparam logic [9:0] MIWS_VEC_TIMER  = 10'h009;
   localparam logic [9:0] MIWS_VEC_CONV   = 10'h00C;
   localparam logic [9:0] MIWS_VEC_CMP    = 10'h00F;
   localparam logic [9:0] MIWS_VEC_T1     = 10'h012;
   localparam logic [9:0] MIWS_VEC_T2     = 10'h015;
   localparam logic [9:0] MIWS_VEC_T3     = 10'h018;
   localparam logic [9:0] MIWS_VEC_LVD    = 10'h01B;
   localparam logic [8:0] MIWS_FLAG_RST   = 9'h000;
   localparam logic [8:0] MIWS_MASK_RST   = 9'h000;
   localparam logic [2:0] MIWS_CTRL_RST   = 3'h0;

   // Noise filter: least pulse of 8 system clock periods
   localparam int MIWS_FILT_CYC = 8;
endpackage

// ### verification/miws_core_model.sv
`timescale 1ns/10ps
`default_nettype none
// Core sequencer stand-in: instruction strobes, sleep state, dispatch log
module miws_core_model
   import miws_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Bench command: 0 on, 1 off, 2 return, 3 sleep, 4 watchdog clear
   input  wire logic [2:0]  op,
   input  wire logic        op_go,
   // From the controller
   input  wire logic        vector_req,
   input  wire logic [9:0]  vector_addr,
   input  wire logic        wake,
   input  wire logic        core_reset,
   // To the controller
   output logic [4:0]       instr,
   output logic             asleep,
   output logic [23:0]      work_set_in,
   // Dispatch log for the bench
   output logic [7:0]       svc_cnt,
   output logic [9:0]       svc_addr,
   output logic [23:0]      svc_ws
);
   logic [23:0] prev_ws;

   // Work set moves every cycle, so a capture on the wrong edge shows up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr       <= 5'h00;
         asleep      <= 1'b0;
         work_set_in <= 24'hA51C3E;
         prev_ws     <= 24'h000000;
         svc_cnt     <= 8'h00;
         svc_addr    <= 10'h000;
         svc_ws      <= 24'h000000;
      end else begin
         instr       <= op_go ? (5'h01 << op) : 5'h00;
         work_set_in <= work_set_in + 24'h1357B9;
         prev_ws     <= work_set_in;
         if (core_reset || wake) begin
            asleep <= 1'b0;
         end else if (instr[3]) begin
            asleep <= 1'b1;
         end
         if (vector_req) begin
            svc_cnt  <= svc_cnt + 8'h01;
            svc_addr <= vector_addr;
            svc_ws   <= prev_ws;
         end
      end
   end
endmodule
`default_nettype wire

// ### verification/tb_mcu_interrupt_wake_status.sv
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_interrupt_wake_status
   import miws_pkg::*;
;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rnd, seed;
   logic        port6_read, pin_reset_n, low_voltage_reset, watchdog_timeout, ext_pin;
   logic        base_timer_ovf, conv_done, cmp_change, lvd_event, op_go, asleep, core_reset;
   logic        wake, vector_req, watchdog_cause, dozed;
   logic [7:0]  port6_in, svc_cnt, c0;
   logic [2:0]  timer_match, op;
   logic [4:0]  instr;
   logic [9:0]  vector_addr, svc_addr;
   logic [23:0] work_set_in, work_set_out, svc_ws;
   int          mismatches, checked, n, pend, best, rst_cnt, rst_base;
   // Priority number and vector, indexed by flag bit position
   int          prio [9] = '{4, 3, 2, 5, 7, 8, 9, 6, 1};
   logic [9:0]  vec [9] = '{10'h009, 10'h006, 10'h003, 10'h00C, 10'h012, 10'h015, 10'h018, 10'h00F, 10'h01B};

   miws_ctrl i_miws_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .irq_global_on_instr(instr[0]), .irq_global_off_instr(instr[1]), .irq_return_instr(instr[2]),
      .sleep_instr(instr[3]), .watchdog_clear_instr(instr[4]), .asleep, .pin_reset_n, .low_voltage_reset,
      .watchdog_timeout, .ext_pin, .port6_in, .port6_read, .base_timer_ovf, .conv_done, .cmp_change,
      .timer_match, .lvd_event, .work_set_in, .core_reset, .wake, .vector_req, .vector_addr, .work_set_out,
      .watchdog_cause, .dozed);
   miws_core_model i_miws_core_model (.pclk, .presetn, .op, .op_go, .vector_req, .vector_addr, .wake,
      .core_reset, .instr, .asleep, .work_set_in, .svc_cnt, .svc_addr, .svc_ws);

   // ------------------------------------------------------------------
   // Clock, helpers
   // ------------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Count core reset cycles; one driver only, rows compare before and after
   always @(posedge pclk) begin
      if (core_reset === 1'b1) begin
         rst_cnt <= rst_cnt + 1;
      end
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic hang();
      mismatches++;
      finish_test();
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge pclk);
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      if (i >= 20) hang();
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic do_op(input logic [2:0] code);
      op    <= code;
      op_go <= 1'b1;
      @(posedge pclk);
      op_go <= 1'b0;
      cyc(3);
   endtask

   // Port 6 reference read first, optional sleep, then a random pin change
   task automatic p6(input logic s);
      port6_read <= 1'b1;
      @(posedge pclk);
      port6_read <= 1'b0;
      if (s) do_op(3'h3);
      rnd = xs();
      cyc(2);
      port6_in <= port6_in ^ (rnd[7:0] | 8'h01);
      cyc(5);
      // Port read as a service routine would do, so the change stops re-raising the flag
      port6_read <= 1'b1;
      @(posedge pclk);
      port6_read <= 1'b0;
   endtask

   task automatic wait_svc();
      for (n = 0; n < 60 && svc_cnt === c0; n++) @(posedge pclk);
      if (n >= 60) hang();
   endtask

   // Pulse on the external input; spurious edge from the setup is cleared first
   task automatic ext_row(input logic e, input logic low_freq_crystal_mode, input int len, input logic hit);
      apb(1'b1, MIWS_OFF_CTRL, {30'h0, low_freq_crystal_mode, e});
      ext_pin <= e;
      cyc(12);
      apb(1'b1, MIWS_OFF_FLAG, 32'h4);
      ext_pin <= ~e;
      cyc(len);
      ext_pin <= e;
      cyc(12);
      apb(1'b0, MIWS_OFF_FLAG, 32'h0);
      chk(rd & 32'h4, hit ? 32'h4 : 32'h0);
      apb(1'b1, MIWS_OFF_FLAG, 32'h4);
   endtask

   // Cause bits after an event; ev 0 watchdog, 1 pin reset, 2 low voltage
   task automatic cause_row(input logic s, input int ev, input logic wden, input logic t, input logic p,
                            input logic r);
      do_op(3'h4);
      chk({30'h0, watchdog_cause, dozed}, 32'h3);
      if (s) do_op(3'h3);
      if (s) chk({30'h0, watchdog_cause, dozed}, 32'h2);
      apb(1'b1, MIWS_OFF_CTRL, {29'h0, wden, 2'h0});
      rst_base = rst_cnt;
      watchdog_timeout  <= (ev == 0);
      pin_reset_n       <= (ev != 1);
      low_voltage_reset <= (ev == 2);
      cyc(2);
      watchdog_timeout  <= 1'b0;
      pin_reset_n       <= 1'b1;
      low_voltage_reset <= 1'b0;
      cyc(6);
      chk({30'h0, watchdog_cause, dozed}, {30'h0, t, p});
      if (ev != 2) chk({31'h0, rst_cnt != rst_base}, {31'h0, r});
   endtask

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial begin
      seed = 32'h2349;
      {presetn, psel, penable, pwrite, paddr, pwdata, op, op_go, ext_pin, port6_read} = '0;
      {base_timer_ovf, conv_done, cmp_change, timer_match, lvd_event} = '0;
      {low_voltage_reset, watchdog_timeout, mismatches, checked} = '0;
      pin_reset_n = 1'b1;
      port6_in = 8'h5A;
      cyc(5);
      presetn <= 1'b1;
      @(posedge pclk);
      // Power-on state, read-only status, unmapped word
      chk({30'h0, watchdog_cause, dozed}, 32'h3);
      apb(1'b1, MIWS_OFF_STATUS, 32'hFFFFFFFF);
      apb(1'b0, MIWS_OFF_STATUS, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      apb(1'b1, MIWS_OFF_MASK, 32'h4);
      ext_row(1'b0, 1'b0, 7, 1'b0);
      ext_row(1'b0, 1'b0, 8, 1'b1);
      ext_row(1'b1, 1'b0, 7, 1'b0);
      ext_row(1'b1, 1'b0, 8, 1'b1);
      ext_row(1'b0, 1'b1, 2, 1'b1);
      $display("test filter done");
      // Events with mask clear, then read through a random mask
      apb(1'b1, MIWS_OFF_MASK, 32'h0);
      p6(1'b0);
      {base_timer_ovf, conv_done, cmp_change, timer_match, lvd_event} <= 7'h7F;
      @(posedge pclk);
      {base_timer_ovf, conv_done, cmp_change, timer_match, lvd_event} <= 7'h00;
      rnd = xs();
      apb(1'b1, MIWS_OFF_MASK, rnd);
      apb(1'b0, MIWS_OFF_FLAG, 32'h0);
      chk(rd, rnd & 32'h1F9);
      apb(1'b1, MIWS_OFF_MASK, 32'h1FF);
      ext_pin <= 1'b1;
      cyc(12);
      ext_pin <= 1'b0;
      p6(1'b0);
      apb(1'b0, MIWS_OFF_FLAG, 32'h0);
      chk(rd, 32'h1FF);
      c0 = svc_cnt;
      cyc(10);
      chk({24'h0, svc_cnt}, {24'h0, c0});
      do_op(3'h0);
      pend = 32'h1FF;
      // Expected order: smallest priority number among what is still pending
      for (int k = 0; k < 9; k++) begin
         wait_svc();
         best = -1;
         for (int j = 0; j < 9; j++) if (pend[j] && (best < 0 || prio[j] < prio[best])) best = j;
         chk({22'h0, svc_addr}, {22'h0, vec[best]});
         chk({8'h0, work_set_out}, {8'h0, svc_ws});
         pend = pend & ~(1 << best);
         apb(1'b1, MIWS_OFF_FLAG, 1 << best);
         apb(1'b0, MIWS_OFF_FLAG, 32'h0);
         chk(rd, pend);
         c0 = svc_cnt;
         do_op(3'h2);
      end
      cyc(10);
      chk({24'h0, svc_cnt}, {24'h0, c0});
      $display("test dispatch done");
      // Pin-change wake with global enable off, then on
      for (int g = 0; g < 2; g++) begin
         do_op(g ? 3'h0 : 3'h1);
         c0 = svc_cnt;
         p6(1'b1);
         chk({31'h0, asleep}, 32'h0);
         chk({24'h0, svc_cnt}, {24'h0, c0} + g);
         if (g) chk({22'h0, svc_addr}, 32'h6);
         chk({30'h0, watchdog_cause, dozed}, 32'h2);
         apb(1'b1, MIWS_OFF_FLAG, 32'h2);
         if (g) do_op(3'h2);
      end
      $display("test wake done");
      cause_row(1'b0, 0, 1'b1, 1'b0, 1'b1, 1'b1);
      cause_row(1'b1, 0, 1'b1, 1'b0, 1'b0, 1'b1);
      cause_row(1'b0, 0, 1'b0, 1'b0, 1'b1, 1'b0);
      cause_row(1'b0, 1, 1'b0, 1'b1, 1'b1, 1'b1);
      cause_row(1'b1, 1, 1'b0, 1'b1, 1'b0, 1'b1);
      cause_row(1'b0, 2, 1'b0, 1'b1, 1'b1, 1'b0);
      cause_row(1'b1, 2, 1'b0, 1'b1, 1'b0, 1'b0);
      $display("test causes done");
      finish_test();
   end
endmodule
`default_nettype wire
